// *** src/reg_attr_pkg.sv ***
// Function
// R1: Read-only bits return their value and ignore all writes.
// R2: Clear-on-read bits return contents then clear; writes ignored.
// R3: Write-only bits accept writes; read value is unspecified.
// R4: Write-one-to-clear bits clear on a one, keep on a zero.
// R5: Latch-low status stays low until read, then follows condition.
// R6: Latch-high status stays high until read, then follows condition.
// R7: Self-clearing bits set by writing one, then return to zero.
// R8: Host writes zeros to reserved fields and ignores their reads.
// R9: All registers reachable by any management port; PHY via its port. The code lets the PHY management port reach only phy_space requests.
// R10: Read-write bits hold the last written value until write or reset.
`default_nettype none
package reg_attr_pkg;
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;

  // Register indices, one attribute each
  localparam logic [2:0] IDX_RW  = 3'h0;
  localparam logic [2:0] IDX_RO  = 3'h1;
  localparam logic [2:0] IDX_RC  = 3'h2;
  localparam logic [2:0] IDX_WO  = 3'h3;
  localparam logic [2:0] IDX_W1C = 3'h4;
  localparam logic [2:0] IDX_LL  = 3'h5;
  localparam logic [2:0] IDX_LH  = 3'h6;
  localparam logic [2:0] IDX_SC  = 3'h7;

  // Reset values and reserved-field mask
  localparam logic [7:0] RST_RW = 8'h00;
  localparam logic [7:0] RST_WO = 8'h00;
  localparam logic [7:0] RST_LL = 8'hFF;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RSVD_MASK = 8'h7F;

  // Management port selection
  typedef enum logic [1:0] {
    PORT_SERIAL,
    PORT_TWO_WIRE,
    PORT_PHY_MGMT
  } mgmt_port_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       phy_space;
  } reg_req_t;
endpackage : reg_attr_pkg
`default_nettype wire

// *** src/register_access_attribute_logic.sv ***
`default_nettype none
module register_access_attribute_logic (
  // Clock and reset
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_rst_b,
  // Requests from the three management ports
  input  wire reg_attr_pkg::reg_req_t   i_req_serial,
  input  wire reg_attr_pkg::reg_req_t   i_req_two_wire,
  input  wire reg_attr_pkg::reg_req_t   i_req_phy_mgmt,
  // Status conditions and sources from the core
  input  wire logic [7:0]               i_ro_value,
  input  wire logic [7:0]               i_rc_event,
  input  wire logic [7:0]               i_w1c_event,
  input  wire logic [7:0]               i_ll_cond,
  input  wire logic [7:0]               i_lh_cond,
  // Read answer
  output logic                          o_rd_valid,
  output logic [7:0]                    o_rd_data,
  output logic [1:0]                    o_rd_port,
  output logic                          o_rd_error,
  // Control outputs to the core
  output logic [7:0]                    o_rw_ctrl,
  output logic [7:0]                    o_wo_ctrl,
  output logic [7:0]                    o_sc_pulse
);

  logic [7:0] rw_reg;
  logic [7:0] wo_reg;
  logic [7:0] rc_reg;
  logic [7:0] w1c_reg;
  logic [7:0] ll_reg;
  logic [7:0] lh_reg;
  logic [7:0] sc_reg;
  reg_attr_pkg::reg_req_t req;
  reg_attr_pkg::mgmt_port_t port;
  logic       wr;
  logic       rd;
  logic       phy_denied;

  function automatic logic hit(input logic [2:0] a, input logic [2:0] idx);
    hit = (a == idx);
  endfunction : hit

  // R9 port arbitration
  always_comb begin
    if (i_req_serial.valid) begin
      req  = i_req_serial;
      port = reg_attr_pkg::PORT_SERIAL;
    end else if (i_req_two_wire.valid) begin
      req  = i_req_two_wire;
      port = reg_attr_pkg::PORT_TWO_WIRE;
    end else begin
      req  = i_req_phy_mgmt;
      port = reg_attr_pkg::PORT_PHY_MGMT;
    end
  end

  // R9 phy port limited to phy space
  assign phy_denied = (port == reg_attr_pkg::PORT_PHY_MGMT) && !req.phy_space;
  assign wr = req.valid && req.write && !phy_denied;
  assign rd = req.valid && !req.write && !phy_denied;

  // R10 read-write storage
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rw_reg <= reg_attr_pkg::RST_RW;
    end else if (wr && hit(req.addr, reg_attr_pkg::IDX_RW)) begin
      rw_reg <= req.wdata & reg_attr_pkg::RSVD_MASK;
    end
  end

  // R3 write-only storage
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wo_reg <= reg_attr_pkg::RST_WO;
    end else if (wr && hit(req.addr, reg_attr_pkg::IDX_WO)) begin
      wo_reg <= req.wdata;
    end
  end

  // R2 clear on read, event wins
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rc_reg <= reg_attr_pkg::RST_ZERO;
    end else if (rd && hit(req.addr, reg_attr_pkg::IDX_RC)) begin
      rc_reg <= i_rc_event;
    end else begin
      rc_reg <= rc_reg | i_rc_event;
    end
  end

  // R4 write one to clear, event wins
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      w1c_reg <= reg_attr_pkg::RST_ZERO;
    end else if (wr && hit(req.addr, reg_attr_pkg::IDX_W1C)) begin
      w1c_reg <= (w1c_reg & ~req.wdata) | i_w1c_event;
    end else begin
      w1c_reg <= w1c_reg | i_w1c_event;
    end
  end

  // R5 latch low, read releases
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ll_reg <= reg_attr_pkg::RST_LL;
    end else if (rd && hit(req.addr, reg_attr_pkg::IDX_LL)) begin
      ll_reg <= i_ll_cond;
    end else begin
      ll_reg <= ll_reg & i_ll_cond;
    end
  end

  // R6 latch high, read releases
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lh_reg <= reg_attr_pkg::RST_ZERO;
    end else if (rd && hit(req.addr, reg_attr_pkg::IDX_LH)) begin
      lh_reg <= i_lh_cond;
    end else begin
      lh_reg <= lh_reg | i_lh_cond;
    end
  end

  // R7 self clearing after one cycle
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sc_reg <= reg_attr_pkg::RST_ZERO;
    end else if (wr && hit(req.addr, reg_attr_pkg::IDX_SC)) begin
      sc_reg <= req.wdata;
    end else begin
      sc_reg <= reg_attr_pkg::RST_ZERO;
    end
  end

  // Read answer
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rd_valid <= 1'b0;
      o_rd_data  <= reg_attr_pkg::RST_ZERO;
      o_rd_port  <= 2'h0;
      o_rd_error <= 1'b0;
    end else begin
      o_rd_valid <= req.valid && !req.write;
      o_rd_port  <= port;
      o_rd_error <= req.valid && !req.write && phy_denied;
      if (!rd) begin
        o_rd_data <= reg_attr_pkg::RST_ZERO;
      end else if (hit(req.addr, reg_attr_pkg::IDX_RW)) begin
        o_rd_data <= rw_reg;
      end else if (hit(req.addr, reg_attr_pkg::IDX_RO)) begin
        // R1 read-only returns live value
        o_rd_data <= i_ro_value;
      end else if (hit(req.addr, reg_attr_pkg::IDX_RC)) begin
        o_rd_data <= rc_reg;
      end else if (hit(req.addr, reg_attr_pkg::IDX_WO)) begin
        // R3 write-only reads zero
        o_rd_data <= reg_attr_pkg::RST_ZERO;
      end else if (hit(req.addr, reg_attr_pkg::IDX_W1C)) begin
        o_rd_data <= w1c_reg;
      end else if (hit(req.addr, reg_attr_pkg::IDX_LL)) begin
        o_rd_data <= ll_reg;
      end else if (hit(req.addr, reg_attr_pkg::IDX_LH)) begin
        o_rd_data <= lh_reg;
      end else begin
        o_rd_data <= sc_reg;
      end
    end
  end

  assign o_rw_ctrl  = rw_reg;
  assign o_wo_ctrl  = wo_reg;
  assign o_sc_pulse = sc_reg;

  // R10 hold between writes
  chk_rw_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    !(wr && hit(req.addr, reg_attr_pkg::IDX_RW)) |=> $stable(rw_reg))
    else $error("rw register changed without write");
  // R1 read-only live value
  chk_ro_read: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (rd && hit(req.addr, reg_attr_pkg::IDX_RO)) |=> (o_rd_data == $past(i_ro_value)))
    else $error("read-only read mismatch");
  // R2 cleared after read
  chk_rc_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (rd && hit(req.addr, reg_attr_pkg::IDX_RC)) |=> (rc_reg == $past(i_rc_event)))
    else $error("clear-on-read not cleared");
  // R4 no bit sets without event unless a bit clears
  chk_w1c_keep: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (w1c_reg != 8'h00) |=> ((w1c_reg & ~$past(w1c_reg)) == 8'h00 || $past(i_w1c_event) != 8'h00)
      or ((($past(w1c_reg) & ~w1c_reg)) != 8'h00))
    else $error("w1c bit set without event");
  // R5 latch low holds
  chk_ll_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    !(rd && hit(req.addr, reg_attr_pkg::IDX_LL)) |=> ((ll_reg & ~$past(ll_reg)) == 8'h00))
    else $error("latched low bit rose without read");
  // R6 latch high holds
  chk_lh_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    !(rd && hit(req.addr, reg_attr_pkg::IDX_LH)) |=> ((~lh_reg & $past(lh_reg)) == 8'h00))
    else $error("latched high bit fell without read");
  // R7 self clear next cycle
  chk_sc_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (sc_reg != 8'h00) && !wr |=> (sc_reg == 8'h00))
    else $error("self-clearing bit stuck");
  // R9 phy port restricted
  chk_phy_denied: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (req.valid && !req.write && phy_denied) |=> (o_rd_error && o_rd_data == 8'h00))
    else $error("phy port reached switch space");
  // R3 write-only stored
  chk_wo_store: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (wr && hit(req.addr, reg_attr_pkg::IDX_WO)) |=> (o_wo_ctrl == $past(req.wdata)))
    else $error("write-only not stored");

  cov_rc_read: cover property (@(posedge i_clk_sys) rd && hit(req.addr, reg_attr_pkg::IDX_RC) && rc_reg != 8'h00);
  cov_w1c_write: cover property (@(posedge i_clk_sys) wr && hit(req.addr, reg_attr_pkg::IDX_W1C));
  cov_sc_pulse: cover property (@(posedge i_clk_sys) sc_reg != 8'h00);
  cov_two_wire: cover property (@(posedge i_clk_sys) rd && port == reg_attr_pkg::PORT_TWO_WIRE);
  cov_phy_denied: cover property (@(posedge i_clk_sys) req.valid && phy_denied);

  // R9 read answer one cycle later
  chk_rd_answer: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    (req.valid && !req.write) |=> (o_rd_valid && o_rd_port == $past(port)))
    else $error("read answer missing");
  // R9 no answer without read
  chk_rd_quiet: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    !(req.valid && !req.write) |=> (!o_rd_valid && o_rd_data == 8'h00))
    else $error("read answer without request");

endmodule : register_access_attribute_logic
`default_nettype wire

// *** bench/host_model.sv ***
`default_nettype none
module host_model (
  // Clock and answer
  input  wire logic                  i_clk_sys,
  input  wire logic [7:0]            i_rd_data,
  input  wire logic                  i_rd_error,
  // Requests
  output var reg_attr_pkg::reg_req_t o_req_serial,
  output var reg_attr_pkg::reg_req_t o_req_two_wire,
  output var reg_attr_pkg::reg_req_t o_req_phy_mgmt
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {o_req_serial, o_req_two_wire, o_req_phy_mgmt} = '0;
  end
  task automatic access(input int port, input logic wr, input logic [2:0] addr, input logic [7:0] wdata,
                        input logic phy, output logic [7:0] rdata, output logic err);
    reg_attr_pkg::reg_req_t req;
    req = '{valid: 1'b1, write: wr, addr: addr, wdata: wdata, phy_space: phy};
    if (addr == reg_attr_pkg::IDX_RW) req.wdata = wdata & reg_attr_pkg::RSVD_MASK;
    @(posedge i_clk_sys);
    #1;
    if (port == 0) o_req_serial = req;
    else if (port == 1) o_req_two_wire = req;
    else o_req_phy_mgmt = req;
    @(posedge i_clk_sys);
    #1;
    {o_req_serial, o_req_two_wire, o_req_phy_mgmt} = '0;
    rdata = i_rd_data;
    err = i_rd_error;
  endtask : access
endmodule : host_model
`default_nettype wire

// *** bench/test_register_access_attribute_logic.sv ***
`default_nettype none
module test_register_access_attribute_logic;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk_sys = 1'b0;
  logic i_rst_b = 1'b0;
  reg_attr_pkg::reg_req_t rq_s, rq_t, rq_p;
  logic [7:0] ro = '0, rce = '0, wce = '0, llc = 8'hFF, lhc = '0;
  logic rd_valid, rd_error;
  logic [7:0] rd_data, rw_ctrl, wo_ctrl, sc_pulse;
  logic [1:0] rd_port;
  int n_mismatch = 0, total_checks = 0, cycles = 0, seed = 85608;
  logic [7:0] v, m, d;
  logic e;
  always #5 i_clk_sys = ~i_clk_sys;
  register_access_attribute_logic register_access_attribute_logic_i (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
    .i_req_serial(rq_s), .i_req_two_wire(rq_t), .i_req_phy_mgmt(rq_p), .i_ro_value(ro), .i_rc_event(rce),
    .i_w1c_event(wce), .i_ll_cond(llc), .i_lh_cond(lhc), .o_rd_valid(rd_valid), .o_rd_data(rd_data),
    .o_rd_port(rd_port), .o_rd_error(rd_error), .o_rw_ctrl(rw_ctrl), .o_wo_ctrl(wo_ctrl), .o_sc_pulse(sc_pulse));
  host_model host_model_i (.i_clk_sys(i_clk_sys), .i_rd_data(rd_data), .i_rd_error(rd_error),
    .o_req_serial(rq_s), .o_req_two_wire(rq_t), .o_req_phy_mgmt(rq_p));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic rd(input int p, input logic [2:0] a, output logic [7:0] q);
    host_model_i.access(p, 1'b0, a, 8'h00, 1'b1, q, e);
    check("rd_valid", {7'h00, rd_valid}, 8'h01);
  endtask : rd
  task automatic wr(input int p, input logic [2:0] a, input logic [7:0] w);
    host_model_i.access(p, 1'b1, a, w, 1'b1, d, e);
  endtask : wr
  task automatic pulse(ref logic [7:0] s, input logic [7:0] x, input logic [7:0] idle);
    @(posedge i_clk_sys);
    #1 s = x;
    @(posedge i_clk_sys);
    #1 s = idle;
  endtask : pulse
  always @(posedge i_clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    repeat (16) @(posedge i_clk_sys);
    #1 i_rst_b = 1'b1;
    for (int i = 0; i < 4; i++) begin
      v = $random(seed) | 8'h01;
      m = $random(seed);
      for (int p = 0; p < 3; p++) begin
        wr(p, reg_attr_pkg::IDX_RW, v ^ p[7:0]);
        rd((p + 1) % 3, reg_attr_pkg::IDX_RW, d);
        check("rw", d, (v ^ p[7:0]) & 8'h7F);
        check("rd_port", {6'h00, rd_port}, 8'((p + 1) % 3));
      end
      host_model_i.access(2, 1'b1, reg_attr_pkg::IDX_RW, m, 1'b0, d, e);
      check("rw_ctrl", rw_ctrl, (v ^ 8'h02) & 8'h7F);
      host_model_i.access(2, 1'b0, reg_attr_pkg::IDX_RO, 8'h00, 1'b0, d, e);
      check("phy_err", {7'h00, e}, 8'h01);
      ro = m;
      wr(0, reg_attr_pkg::IDX_RO, ~m);
      rd(0, reg_attr_pkg::IDX_RO, d);
      check("ro", d, m);
      pulse(rce, v, 8'h00);
      wr(1, reg_attr_pkg::IDX_RC, 8'hFF);
      rd(0, reg_attr_pkg::IDX_RC, d);
      check("rc", d, v);
      rd(0, reg_attr_pkg::IDX_RC, d);
      check("rc_clr", d, 8'h00);
      wr(0, reg_attr_pkg::IDX_WO, m);
      check("wo", wo_ctrl, m);
      rd(0, reg_attr_pkg::IDX_WO, d);
      check("wo_rd", d, 8'h00);
      pulse(wce, v, 8'h00);
      wr(0, reg_attr_pkg::IDX_W1C, m);
      rd(0, reg_attr_pkg::IDX_W1C, d);
      check("w1c", d, v & ~m);
      wr(0, reg_attr_pkg::IDX_W1C, 8'hFF);
      pulse(llc, ~v, 8'hFF);
      rd(1, reg_attr_pkg::IDX_LL, d);
      check("ll", d, ~v);
      rd(1, reg_attr_pkg::IDX_LL, d);
      check("ll_rel", d, 8'hFF);
      pulse(lhc, v, 8'h00);
      rd(1, reg_attr_pkg::IDX_LH, d);
      check("lh", d, v);
      rd(1, reg_attr_pkg::IDX_LH, d);
      check("lh_rel", d, 8'h00);
      wr(0, reg_attr_pkg::IDX_SC, v);
      check("sc", sc_pulse, v);
      @(posedge i_clk_sys);
      #1 check("sc_end", sc_pulse, 8'h00);
      wr(0, reg_attr_pkg::IDX_SC, 8'h00);
      check("sc_zero", sc_pulse, 8'h00);
      rd(0, reg_attr_pkg::IDX_SC, d);
      check("sc_rd", d, 8'h00);
    end
    wrap_up();
  end
endmodule : test_register_access_attribute_logic
`default_nettype wire
